// file: hdl/effective_address_unit.sv
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Contract
// RULE1: Each memory reference carries one of four types
// RULE2: Opcode 15:11, post 10, indirect 9, pre 8, displacement
// RULE3: Displacement is sign-extended two's complement
// RULE4: No mode bits: address is PC plus displacement
// RULE5: Pre-index replaces PC as base, before indirection
// RULE6: Indirect: base plus displacement reads address word
// RULE7: Post-index added after indirection or directly
// RULE8: Indexing costs nothing; indirect costs one cycle
// RULE9: Indirect word to holding register, then plus post-index
// RULE10: Fetch uses PC and increments it by one
// RULE11: Non-fetch uses adder; only store writes
// RULE12: Fetch latches PC and raises request together
// RULE13: Fetched word loads instruction and holding registers
// RULE14: Three mode bits steer adder operand selectors
// RULE15: Cycle type from microinstruction bits 21 to 23
// RULE16: Two adders plus selectors form the address
// RULE17: Jump, byte, register-block skip mode decoding
// RULE18: Virtual address is 16 bits to translation
// RULE19: Request held until memory signals data ready
// RULE20: Additions are modulo two to the sixteenth
module effective_address_unit (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Microcode side
  input wire logic cycle_start_i,
  input wire logic [31:0] microinstruction_register_i,
  input wire logic exclude_mode_i,
  input wire logic [15:0] pre_index_i,
  input wire logic [15:0] post_index_i,
  output logic start_ready_o,
  output logic cycle_done_o,
  output logic [15:0] instr_reg_o,
  output logic [15:0] hold_reg_o,
  output logic [15:0] fetch_pointer_o,
  // Memory side
  output ea_pkg::mem_req_t mem_o,
  input wire logic mem_data_ready_i,
  input wire logic [15:0] mem_rdata_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ea_pkg::fsm_state_t fsm;
    logic [15:0] pc;
    ea_pkg::mem_req_t mem;
    logic [15:0] ir;
    logic [15:0] hold;
    logic ind_done;
    logic done;
    logic enable;
    logic [15:0] rdata;
    logic rdy_meta;
    logic rdy_sync;
  } state_t;

  state_t s_q;
  state_t s_d;

  ea_pkg::mode_bits_t mode;
  ea_pkg::cycle_type_t ctype;
  logic [15:0] a1;
  logic [15:0] b1;
  logic [15:0] a2;
  logic [15:0] b2;
  logic [15:0] sum1;
  logic [15:0] sum2;
  logic start;
  logic [15:0] status_word;
  logic [15:0] cyc_vaddr;
  logic cyc_write;
  logic ld_ir;
  logic ld_hold;
  logic set_ind;
  logic clr_ind;
  logic [15:0] rd_word;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign mode = ea_pkg::decode_mode(s_q.ir); // [RULE2] [RULE14]
  assign ctype = ea_pkg::decode_ctype(
    microinstruction_register_i[ea_pkg::MIR_CT_MSB:ea_pkg::MIR_CT_LSB]); // [RULE15]

  // ---------------------------------------------------------------
  // Address datapath
  // ---------------------------------------------------------------
  ea_operand_select u_select (
    .mode_i(mode),
    .exclude_i(exclude_mode_i),
    .ind_done_i(s_q.ind_done),
    .pc_i(s_q.pc),
    .pre_index_i(pre_index_i),
    .post_index_i(post_index_i),
    .hold_i(s_q.hold),
    .sum1_i(sum1),
    .a1_o(a1),
    .b1_o(b1),
    .a2_o(a2),
    .b2_o(b2)
  );

  // Base plus displacement
  ea_adder #(.W(ea_pkg::ADDR_W)) u_adder_base ( // [RULE16]
    .a_i(a1),
    .b_i(b1),
    .sum_o(sum1)
  );

  // Post-index stage
  ea_adder #(.W(ea_pkg::ADDR_W)) u_adder_post ( // [RULE16]
    .a_i(a2),
    .b_i(b2),
    .sum_o(sum2)
  );

  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  // New cycle only once memory has dropped its previous ready
  assign start = cycle_start_i && (s_q.fsm == ea_pkg::ST_IDLE) && s_q.enable &&
                 (ctype != ea_pkg::CT_NONE) && !s_q.rdy_sync;
  assign start_ready_o = (s_q.fsm == ea_pkg::ST_IDLE) && s_q.enable && !s_q.rdy_sync;

  assign status_word = {10'h000, s_q.ind_done, (s_q.fsm != ea_pkg::ST_IDLE),
                        s_q.mem.req, s_q.mem.ctype};

  // ---------------------------------------------------------------
  // Address and direction of the requested cycle
  // ---------------------------------------------------------------
  always_comb begin
    case (ctype)
      ea_pkg::CT_FETCH: begin
        cyc_vaddr = s_q.pc; // [RULE10] [RULE12] [RULE18]
        cyc_write = 1'b0;
      end
      ea_pkg::CT_INDIRECT_ADDR_READ_CYCLE: begin
        // Base plus displacement, or hold when excluded; post-index waits
        cyc_vaddr = exclude_mode_i ? sum2 : sum1; // [RULE6] [RULE11]
        cyc_write = 1'b0;
      end
      ea_pkg::CT_OPERAND_STORE_CYCLE: begin
        cyc_vaddr = sum2; // [RULE7] [RULE11] [RULE18]
        cyc_write = 1'b1; // [RULE11]
      end
      default: begin
        cyc_vaddr = sum2; // [RULE4] [RULE7] [RULE11]
        cyc_write = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // What an answered cycle loads
  // ---------------------------------------------------------------
  always_comb begin
    ld_ir = 1'b0;
    ld_hold = 1'b0;
    set_ind = 1'b0;
    clr_ind = 1'b0;
    case (s_q.mem.ctype)
      ea_pkg::CT_FETCH: begin
        ld_ir = 1'b1; // [RULE13]
        ld_hold = 1'b1; // [RULE13]
        clr_ind = 1'b1;
      end
      ea_pkg::CT_INDIRECT_ADDR_READ_CYCLE: begin
        ld_hold = 1'b1; // [RULE9]
        set_ind = 1'b1; // [RULE9]
      end
      ea_pkg::CT_OPERAND_READ_CYCLE: begin
        ld_hold = 1'b1;
      end
      default: begin
        ld_hold = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      ea_pkg::REG_CTRL: rd_word = {15'h0000, s_q.enable};
      ea_pkg::REG_PC: rd_word = s_q.pc;
      ea_pkg::REG_VADDR: rd_word = s_q.mem.vaddr;
      ea_pkg::REG_STATUS: rd_word = status_word;
      ea_pkg::REG_INSTR: rd_word = s_q.ir;
      ea_pkg::REG_HOLD: rd_word = s_q.hold;
      default: rd_word = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // Ready comes from the asynchronous memory side
    s_d.rdy_meta = mem_data_ready_i;
    s_d.rdy_sync = s_q.rdy_meta;

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        ea_pkg::REG_CTRL: s_d.enable = reg_wdata_i[ea_pkg::CTRL_EN_BIT];
        ea_pkg::REG_PC: s_d.pc = reg_wdata_i;
        default: s_d.enable = s_q.enable;
      endcase
    end

    // Register reads, answered the next cycle
    s_d.rdata = 16'h0000;
    if (reg_rd_i) begin
      s_d.rdata = rd_word;
    end

    case (s_q.fsm)
      ea_pkg::ST_IDLE: begin
        if (start) begin
          // Address formed in the same step: indexing adds no time
          s_d.mem.req = 1'b1; // [RULE8] [RULE12]
          s_d.mem.ctype = ctype; // [RULE1]
          s_d.fsm = ea_pkg::ST_WAIT;
          s_d.mem.vaddr = cyc_vaddr; // [RULE11] [RULE18]
          s_d.mem.write = cyc_write; // [RULE11]
          if (ctype == ea_pkg::CT_FETCH) begin
            s_d.pc = s_q.pc + ea_pkg::PC_STEP; // [RULE10] [RULE20]
          end
        end
      end
      ea_pkg::ST_WAIT: begin
        if (s_q.rdy_sync) begin
          s_d.mem.req = 1'b0; // [RULE19]
          s_d.done = 1'b1;
          s_d.fsm = ea_pkg::ST_RELEASE;
          if (ld_ir) begin
            s_d.ir = mem_rdata_i; // [RULE13]
          end
          if (ld_hold) begin
            s_d.hold = mem_rdata_i; // [RULE9] [RULE13]
          end
          if (set_ind || clr_ind) begin
            s_d.ind_done = set_ind; // [RULE9]
          end
        end
      end
      ea_pkg::ST_RELEASE: begin
        // Wait for memory to withdraw ready
        if (!s_q.rdy_sync) begin
          s_d.fsm = ea_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.fsm = ea_pkg::ST_IDLE;
        s_d.mem.req = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q.fsm <= ea_pkg::ST_IDLE;
      s_q.pc <= ea_pkg::RST_PC;
      s_q.mem <= '0;
      s_q.ir <= ea_pkg::RST_WORD;
      s_q.hold <= ea_pkg::RST_WORD;
      s_q.ind_done <= 1'b0;
      s_q.done <= 1'b0;
      s_q.enable <= ea_pkg::RST_ENABLE;
      s_q.rdata <= 16'h0000;
      s_q.rdy_meta <= 1'b0;
      s_q.rdy_sync <= 1'b0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign mem_o = s_q.mem;
  assign cycle_done_o = s_q.done;
  assign instr_reg_o = s_q.ir;
  assign hold_reg_o = s_q.hold;
  assign fetch_pointer_o = s_q.pc;
  assign reg_rdata_o = s_q.rdata;

endmodule // effective_address_unit

// file: hdl/ea_pkg.sv
package ea_pkg;

  // ---------------------------------------------------------------
  // Widths and instruction fields
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int DISP_W = 8;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 11;
  localparam int POST_BIT = 10;
  localparam int IND_BIT = 9;
  localparam int PRE_BIT = 8;
  localparam int DISP_MSB = 7;
  localparam int DISP_LSB = 0;
  localparam int MIR_W = 32;
  localparam int MIR_CT_LSB = 21;
  localparam int MIR_CT_MSB = 23;

  // ---------------------------------------------------------------
  // Register port map and reset values
  // ---------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PC = 4'h1;
  localparam logic [3:0] REG_VADDR = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_INSTR = 4'h4;
  localparam logic [3:0] REG_HOLD = 4'h5;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_ENABLE = 1'b1;
  localparam logic [15:0] PC_STEP = 16'h0001;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CT_NONE = 3'h0,
    CT_FETCH = 3'h1,
    CT_OPERAND_READ_CYCLE = 3'h2,
    CT_INDIRECT_ADDR_READ_CYCLE = 3'h3,
    CT_OPERAND_STORE_CYCLE = 3'h4
  } cycle_type_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RELEASE = 3'b100
  } fsm_state_t;

  typedef struct packed {
    logic req;
    logic write;
    cycle_type_t ctype;
    logic [15:0] vaddr;
  } mem_req_t;

  typedef struct packed {
    logic post;
    logic ind;
    logic pre;
    logic [7:0] disp;
  } mode_bits_t;

  function automatic mode_bits_t decode_mode(input logic [15:0] w);
    mode_bits_t m;
    m.post = w[POST_BIT];
    m.ind = w[IND_BIT];
    m.pre = w[PRE_BIT];
    m.disp = w[DISP_MSB:DISP_LSB];
    return m;
  endfunction

  function automatic logic [15:0] sext_disp(input logic [7:0] d);
    return {{(ADDR_W - DISP_W){d[DISP_W - 1]}}, d};
  endfunction

  function automatic cycle_type_t decode_ctype(input logic [2:0] b);
    cycle_type_t c;
    case (b)
      3'h1: c = CT_FETCH;
      3'h2: c = CT_OPERAND_READ_CYCLE;
      3'h3: c = CT_INDIRECT_ADDR_READ_CYCLE;
      3'h4: c = CT_OPERAND_STORE_CYCLE;
      default: c = CT_NONE;
    endcase
    return c;
  endfunction

endpackage

// file: hdl/ea_adder.sv
`timescale 1ns/1ps
module ea_adder #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  output logic [W-1:0] sum_o
);

  // Carry out of the top bit is dropped
  assign sum_o = a_i + b_i; // [RULE20]

endmodule // ea_adder

// file: hdl/ea_operand_select.sv
`timescale 1ns/1ps
module ea_operand_select (
  input wire ea_pkg::mode_bits_t mode_i,
  input wire logic exclude_i,
  input wire logic ind_done_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] pre_index_i,
  input wire logic [15:0] post_index_i,
  input wire logic [15:0] hold_i,
  input wire logic [15:0] sum1_i,
  output logic [15:0] a1_o,
  output logic [15:0] b1_o,
  output logic [15:0] a2_o,
  output logic [15:0] b2_o
);

  always_comb begin
    // First adder: base plus displacement
    a1_o = mode_i.pre ? pre_index_i : pc_i; // [RULE5] [RULE14]
    b1_o = ea_pkg::sext_disp(mode_i.disp); // [RULE3] [RULE4]
    // Second adder: indirect word or first sum, plus post-index
    if (exclude_i) begin
      a2_o = hold_i; // [RULE17]
      b2_o = 16'h0000;
    end else begin
      a2_o = (mode_i.ind && ind_done_i) ? hold_i : sum1_i; // [RULE6] [RULE9]
      b2_o = mode_i.post ? post_index_i : 16'h0000; // [RULE7] [RULE14]
    end
  end

endmodule // ea_operand_select

// file: tb/ea_unit_assertions.sv
`timescale 1ns/1ps
module ea_unit_assertions (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic cycle_start_i,
  input wire logic [31:0] microinstruction_register_i,
  input wire logic exclude_mode_i,
  input wire logic [15:0] pre_index_i,
  input wire logic [15:0] post_index_i,
  input wire logic start_ready_o,
  input wire logic cycle_done_o,
  input wire logic [15:0] instr_reg_o,
  input wire logic [15:0] hold_reg_o,
  input wire logic [15:0] fetch_pointer_o,
  input wire ea_pkg::mem_req_t mem_o,
  input wire logic mem_data_ready_i,
  input wire logic [15:0] mem_rdata_i
);
  // ---------------------------------------------------------------
  // Expected addresses
  // ---------------------------------------------------------------
  logic go;
  logic [2:0] ct;
  logic [15:0] sum1;
  logic [15:0] sum2;
  assign go = cycle_start_i && start_ready_o && clk_en_i;
  assign ct = microinstruction_register_i[23:21];
  assign sum1 = (instr_reg_o[8] ? pre_index_i : fetch_pointer_o)
    + {{8{instr_reg_o[7]}}, instr_reg_o[7:0]};
  assign sum2 = sum1 + (instr_reg_o[10] ? post_index_i : 16'h0000);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_fetch_addr: assert property (go && ct == 3'h1 |=> mem_o.req &&
    mem_o.vaddr == $past(fetch_pointer_o) && fetch_pointer_o == $past(fetch_pointer_o) + 16'h0001)
    else $error("fetch address or step wrong");
  a_cycle_kind: assert property (go && ct != 3'h0 && ct < 3'h5 |=> mem_o.req &&
    mem_o.ctype == $past(ct) && mem_o.write == ($past(ct) == 3'h4))
    else $error("cycle kind or direction wrong");
  a_ind_addr: assert property (go && ct == 3'h3 && !exclude_mode_i |=>
    mem_o.vaddr == $past(sum1)) else $error("indirect read address wrong");
  a_direct_addr: assert property (go && (ct == 3'h2 || ct == 3'h4) && !exclude_mode_i
    && !instr_reg_o[9] |=> mem_o.vaddr == $past(sum2)) else $error("operand address wrong");
  a_excl_addr: assert property (go && ct == 3'h2 && exclude_mode_i |=>
    mem_o.vaddr == $past(hold_reg_o)) else $error("excluded address wrong");
  a_req_hold: assert property (mem_o.req && !mem_data_ready_i |=>
    mem_o.req && $stable(mem_o.vaddr)) else $error("request not held");
  a_done_time: assert property ($rose(mem_data_ready_i) && mem_o.req |->
    ##3 cycle_done_o && !mem_o.req ##1 !cycle_done_o) else $error("done timing wrong");
  a_fetch_load: assert property ($rose(cycle_done_o) && mem_o.ctype == ea_pkg::CT_FETCH |->
    instr_reg_o == $past(mem_rdata_i) && hold_reg_o == $past(mem_rdata_i))
    else $error("fetched word not loaded");
endmodule // ea_unit_assertions

// file: tb/ea_mem_model.sv
`timescale 1ns/1ps
module ea_mem_model (
  input wire logic sys_clk_i,
  input wire ea_pkg::mem_req_t mem_i,
  input wire logic [3:0] delay_i,
  output logic ready_o,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_q = 4'h0;
  logic ready_q = 1'b0;
  logic [15:0] rdata_q = 16'h0000;

  assign ready_o = ready_q;
  assign rdata_o = rdata_q;

  // Answer on the edge after delay_i waiting edges of request; data bus churns while released
  always @(posedge sys_clk_i) begin
    if (!mem_i.req) begin
      ready_q <= 1'b0;
      wait_q <= 4'h0;
      rdata_q <= ~rdata_q;
    end else if (!ready_q && wait_q == delay_i) begin
      ready_q <= 1'b1;
      rdata_q <= mem[mem_i.vaddr[7:0]];
    end else if (!ready_q) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // ea_mem_model

// file: tb/effective_address_unit_tb_top.sv
`timescale 1ns/1ps
module effective_address_unit_tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start = 1'b0;
  logic excl = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] microinstruction_register = 32'h00000000;
  logic [15:0] b_reg = 16'h00c0;
  logic [15:0] x_reg = 16'h0003;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] indirect_addr_read_cycle = 4'h0;
  logic [3:0] dly = 4'h0;
  logic srdy, done, mrdy;
  logic [15:0] ir, hold, pc, mrd, rdata, w, p, ea;
  ea_pkg::mem_req_t mem;
  int num_errors = 0;
  int cmp_count = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  effective_address_unit dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
    .cycle_start_i(start), .microinstruction_register_i(microinstruction_register), .exclude_mode_i(excl),
    .pre_index_i(b_reg), .post_index_i(x_reg), .start_ready_o(srdy), .cycle_done_o(done),
    .instr_reg_o(ir), .hold_reg_o(hold), .fetch_pointer_o(pc), .mem_o(mem),
    .mem_data_ready_i(mrdy), .mem_rdata_i(mrd), .reg_addr_i(indirect_addr_read_cycle), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
  ea_mem_model mem_u (.sys_clk_i(sys_clk_i), .mem_i(mem), .delay_i(dly), .ready_o(mrdy),
    .rdata_o(mrd));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    indirect_addr_read_cycle <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    indirect_addr_read_cycle <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    chk("register", exp, rdata);
  endtask

  task automatic kick(input logic [2:0] ct);
    @(posedge sys_clk_i);
    microinstruction_register <= {8'ha5, ct, 21'h0a5a5a};
    start <= 1'b1;
    @(posedge sys_clk_i);
    start <= 1'b0;
  endtask

  task automatic run_cycle(input logic [2:0] ct, input logic [15:0] va, input logic wr_exp);
    int n;
    kick(ct);
    #1;
    chk("vaddr", va, mem.vaddr);
    chk("write", {15'h0000, wr_exp}, {15'h0000, mem.write});
    for (n = 0; n < 40 && done !== 1'b1; n++) #50;
    chk("done", 16'h0001, {15'h0000, done});
    for (n = 0; n < 40 && srdy !== 1'b1; n++) #50;
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mem_u.mem[i] = {8'hc3, i[7:0]};
    for (int k = 0; k < 8; k++) mem_u.mem[16 + k] = {5'h0b, k[2:0], (k[2] ? 8'h80 : 8'h7f)};
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) reg_rd(a[3:0], {15'h0000, a == 0});
    reg_rd(4'hf, 16'h0000);
    reg_wr(4'h1, 16'h0010);
    reg_rd(4'h1, 16'h0010);
    kick(3'h5);
    #51;
    chk("req", 16'h0000, {15'h0000, mem.req});
    reg_wr(4'h0, 16'h0000);
    reg_rd(4'h0, 16'h0000);
    kick(3'h1);
    #51;
    chk("req", 16'h0000, {15'h0000, mem.req});
    reg_wr(4'h0, 16'h0001);
    @(posedge sys_clk_i);
    clk_en <= 1'b0;
    kick(3'h1);
    #51;
    chk("req", 16'h0000, {15'h0000, mem.req});
    chk("pc", 16'h0010, pc);
    @(posedge sys_clk_i);
    clk_en <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      p = 16'h0010 + k[15:0];
      w = mem_u.mem[16 + k];
      @(posedge sys_clk_i);
      dly <= k[0] ? 4'h0 : 4'h6;
      run_cycle(3'h1, p, 1'b0);
      chk("instr", w, ir);
      chk("hold", w, hold);
      chk("pc", p + 16'h0001, pc);
      ea = (w[8] ? b_reg : p + 16'h0001) + {{8{w[7]}}, w[7:0]};
      if (w[9]) begin
        run_cycle(3'h3, ea, 1'b0);
        ea = {8'hc3, ea[7:0]};
        chk("hold", ea, hold);
      end
      ea = ea + (w[10] ? x_reg : 16'h0000);
      run_cycle((k[2] ^ k[0]) ? 3'h4 : 3'h2, ea, k[2] ^ k[0]);
    end
    run_cycle(3'h1, 16'h0018, 1'b0);
    reg_rd(4'h2, 16'h0018);
    reg_rd(4'h3, 16'h0001);
    @(posedge sys_clk_i);
    excl <= 1'b1;
    run_cycle(3'h2, 16'hc318, 1'b0);
    report_and_stop();
  end

  initial begin
    #1000000;
    num_errors++;
    report_and_stop();
  end
endmodule // effective_address_unit_tb_top

bind effective_address_unit ea_unit_assertions ea_chk_u (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
  .cycle_start_i(cycle_start_i), .exclude_mode_i(exclude_mode_i),
  .microinstruction_register_i(microinstruction_register_i), .pre_index_i(pre_index_i),
  .post_index_i(post_index_i), .start_ready_o(start_ready_o), .cycle_done_o(cycle_done_o),
  .instr_reg_o(instr_reg_o), .hold_reg_o(hold_reg_o), .fetch_pointer_o(fetch_pointer_o),
  .mem_o(mem_o), .mem_data_ready_i(mem_data_ready_i), .mem_rdata_i(mem_rdata_i));
